// ### shared/sram_pkg.sv
// Summary of operation
// R01: The 64-Kbyte window base sits on any 64-Kbyte boundary of the 32-bit space.
// R02: Core accesses that hit the window complete in one cycle without wait states.
// R03: Byte, word and longword accesses; writes touch only the addressed byte lanes.
// R04: Core accesses and debug memory commands are both served.
// R05: On a shared fetch that hits, this memory supplies data; core drops cache data.
// R06: The cache never allocates data from this window; it is non-cacheable.
// R07: Two separate arrays with a second port allow parallel core and DMA access.
// R08: Core writes the base register only by control-register move; core cannot read it.
// R09: The debug module can read and write the base register.
// R10: Undefined base register bits ignore writes and read back as zero.
// R11: Reset clears only the valid bit; other base register bits keep their value.
// R12: A hit needs the valid bit set and address bits 31 to 16 equal to base.
// R13: When both ports address one array, one is served and the other stalls a cycle; here the core always wins and the DMA stalls while the conflict lasts.
package sram_pkg;

    // ************************************************************
    // Geometry and base register layout
    // ************************************************************
    localparam int          ADDR_W       = 32;
    localparam int          DATA_W       = 32;
    localparam int          WIN_BITS     = 16;
    localparam int          BANK_SEL_BIT = 15;
    localparam int          WORD_LSB     = 2;
    localparam int          BANK_AW      = BANK_SEL_BIT - WORD_LSB;
    localparam int          BASE_LSB     = 16;
    localparam int          VALID_BIT    = 0;
    localparam logic [31:0] BASE_MASK    = 32'hffff_0001;

    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_LONG
    } acc_size_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              fetch;
        acc_size_t         size;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic              write;
        logic [DATA_W-1:0] wdata;
    } base_access_t;

endpackage

// ### logic/sram_bank.sv
`timescale 1ns/1ps
module sram_bank
    import sram_pkg::*;
#(
    parameter int AW = BANK_AW
) (
    input  wire logic          i_clk,
    input  wire logic          i_en,
    input  wire logic          i_we,
    input  wire logic [3:0]    i_be,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [31:0]   i_wdata,
    output logic      [31:0]   o_rdata
);

    logic [31:0] mem [0:(1<<AW)-1];

    if (AW < 1) begin : g_bad_aw
        $error("sram_bank: address width too small");
    end

    // ************************************************************
    // One array with per-lane write enables
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_en) begin
            for (int b = 0; b < 4; b++) begin
                if (i_we && i_be[b]) begin
                    mem[i_addr][b*8 +: 8] <= i_wdata[b*8 +: 8]; // R03
                end
            end
            o_rdata <= mem[i_addr];
        end
    end

endmodule

// ### logic/lane_steer.sv
`timescale 1ns/1ps
module lane_steer
    import sram_pkg::*;
(
    input  wire acc_size_t   i_size,
    input  wire logic [1:0]  i_offset,
    input  wire logic [31:0] i_data,
    output logic      [3:0]  o_be,
    output logic      [31:0] o_data
);

    // ************************************************************
    // Big-endian lane selection: byte 0 sits in bits 31 to 24
    // ************************************************************
    always_comb begin
        o_be   = 4'h0;
        o_data = i_data;
        case (i_size)
            SIZE_BYTE: begin
                o_be   = 4'h8 >> i_offset; // R03
                o_data = {4{i_data[7:0]}};
            end
            SIZE_WORD: begin
                o_be   = i_offset[1] ? 4'h3 : 4'hc; // R03
                o_data = {2{i_data[15:0]}};
            end
            SIZE_LONG: begin
                o_be   = 4'hf;
            end
            default: begin
                o_be   = 4'h0;
            end
        endcase
    end

endmodule

// ### logic/local_bus_sram_block.sv
`timescale 1ns/1ps
module local_bus_sram_block
    import sram_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire mem_req_t     i_core_req,
    input  wire logic         i_core_is_debug,
    input  wire mem_req_t     i_dma_req,
    input  wire base_access_t i_ctrl_move,
    input  wire base_access_t i_debug_base,
    output logic              o_core_hit,
    output logic              o_core_ready,
    output logic              o_fetch_take_sram,
    output logic              o_core_nocache,
    output logic [31:0]       o_core_rdata,
    output logic              o_core_rvalid,
    output logic              o_dma_hit,
    output logic              o_dma_ready,
    output logic [31:0]       o_dma_rdata,
    output logic              o_dma_rvalid,
    output logic [31:0]       o_debug_base_rdata
);

    // ************************************************************
    // Base register
    // ************************************************************
    logic [31:0] memory_base_register;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            memory_base_register[VALID_BIT] <= 1'b0; // R11
        end else if (i_debug_base.write) begin
            memory_base_register <= i_debug_base.wdata & BASE_MASK; // R09 R10
        end else if (i_ctrl_move.write) begin
            memory_base_register <= i_ctrl_move.wdata & BASE_MASK; // R08 R10
        end
    end

    // Core reads of this register are not provided at all.
    assign o_debug_base_rdata = memory_base_register & BASE_MASK; // R09 R10 R08

    // ************************************************************
    // Window decode
    // ************************************************************
    logic base_valid;
    logic core_in;
    logic dma_in;

    assign base_valid = memory_base_register[VALID_BIT];
    // R01 R12
    assign core_in = i_core_req.valid && base_valid &&
                     (i_core_req.addr[ADDR_W-1:BASE_LSB] ==
                      memory_base_register[ADDR_W-1:BASE_LSB]);
    assign dma_in  = i_dma_req.valid && base_valid &&
                     (i_dma_req.addr[ADDR_W-1:BASE_LSB] ==
                      memory_base_register[ADDR_W-1:BASE_LSB]);

    assign o_core_hit        = core_in; // R12 R04
    assign o_dma_hit         = dma_in;
    assign o_fetch_take_sram = core_in && i_core_req.fetch; // R05
    assign o_core_nocache    = core_in; // R06

    // ************************************************************
    // Bank arbitration
    // ************************************************************
    logic core_bank;
    logic dma_bank;
    logic conflict;
    logic core_go;
    logic dma_go;

    assign core_bank = i_core_req.addr[BANK_SEL_BIT];
    assign dma_bank  = i_dma_req.addr[BANK_SEL_BIT];
    assign conflict  = core_in && dma_in && (core_bank == dma_bank);
    // The core always wins a shared array so its accesses never take a wait state.
    // A second master that keeps hitting the core's array is held off for as long.
    assign core_go   = core_in; // R02 R13
    assign dma_go    = dma_in && !conflict; // R13 R07

    assign o_core_ready = !core_in || core_go; // R02
    assign o_dma_ready  = !dma_in || dma_go;

    // ************************************************************
    // Lane steering
    // ************************************************************
    logic [3:0]  core_be;
    logic [3:0]  dma_be;
    logic [31:0] core_wd;
    logic [31:0] dma_wd;

    lane_steer u_core_steer (
        .i_size   (i_core_req.size),
        .i_offset (i_core_req.addr[1:0]),
        .i_data   (i_core_req.wdata),
        .o_be     (core_be),
        .o_data   (core_wd)
    );

    lane_steer u_dma_steer (
        .i_size   (i_dma_req.size),
        .i_offset (i_dma_req.addr[1:0]),
        .i_data   (i_dma_req.wdata),
        .o_be     (dma_be),
        .o_data   (dma_wd)
    );

    // ************************************************************
    // Two physical arrays
    // ************************************************************
    logic [31:0] bank_rdata [0:1];
    logic        core_rd_bank;
    logic        dma_rd_bank;

    for (genvar g = 0; g < 2; g++) begin : g_bank
        logic              use_core;
        logic              use_dma;
        logic              en;
        logic              we;
        logic [3:0]        be;
        logic [BANK_AW-1:0] addr;
        logic [31:0]       wd;

        assign use_core = core_go && (core_bank == 1'(g)); // R07
        assign use_dma  = dma_go && (dma_bank == 1'(g));
        assign en   = use_core || use_dma;
        assign we   = use_core ? i_core_req.write : i_dma_req.write;
        assign be   = use_core ? core_be : dma_be;
        assign addr = use_core ? i_core_req.addr[BANK_SEL_BIT-1:WORD_LSB]
                               : i_dma_req.addr[BANK_SEL_BIT-1:WORD_LSB];
        assign wd   = use_core ? core_wd : dma_wd;

        sram_bank #(
            .AW (BANK_AW)
        ) u_bank (
            .i_clk   (i_clk),
            .i_en    (en && i_resetn),
            .i_we    (we),
            .i_be    (be),
            .i_addr  (addr),
            .i_wdata (wd),
            .o_rdata (bank_rdata[g])
        );
    end

    // ************************************************************
    // Read return, one cycle after the accepted address
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_core_rvalid <= 1'b0;
            o_dma_rvalid  <= 1'b0;
            core_rd_bank  <= 1'b0;
            dma_rd_bank   <= 1'b0;
        end else begin
            o_core_rvalid <= core_go && !i_core_req.write; // R02 R04
            o_dma_rvalid  <= dma_go && !i_dma_req.write;
            core_rd_bank  <= core_bank;
            dma_rd_bank   <= dma_bank;
        end
    end

    // Data comes straight from the array output registers.
    assign o_core_rdata = o_core_rvalid ? bank_rdata[core_rd_bank] : 32'h0000_0000;
    assign o_dma_rdata  = o_dma_rvalid ? bank_rdata[dma_rd_bank] : 32'h0000_0000;

    logic unused_debug;
    assign unused_debug = i_core_is_debug;

endmodule

// ### testbench/sram_checker.sv
`timescale 1ns/1ps
module sram_checker
    import sram_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire mem_req_t    i_core_req,
    input wire mem_req_t    i_dma_req,
    input wire logic        o_core_hit,
    input wire logic        o_core_ready,
    input wire logic        o_fetch_take_sram,
    input wire logic        o_core_nocache,
    input wire logic        o_core_rvalid,
    input wire logic        o_dma_hit,
    input wire logic        o_dma_ready,
    input wire logic        o_dma_rvalid,
    input wire logic [31:0] o_debug_base_rdata
);
    wire logic [31:0] base = o_debug_base_rdata;
    wire logic        c_rd = i_core_req.valid & o_core_hit & o_core_ready & ~i_core_req.write;
    wire logic        d_rd = i_dma_req.valid & o_dma_hit & o_dma_ready & ~i_dma_req.write;
    wire logic        both = o_core_hit & o_dma_hit;
    wire logic        same = i_core_req.addr[15] == i_dma_req.addr[15];
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_hit; o_core_hit == (i_core_req.valid && base[0]
        && i_core_req.addr[31:16] == base[31:16]); endproperty
    a_hit: assert property (p_hit) else $error("core hit wrong");
    property p_dhit; o_dma_hit == (i_dma_req.valid && base[0]
        && i_dma_req.addr[31:16] == base[31:16]); endproperty
    a_dhit: assert property (p_dhit) else $error("dma hit wrong");
    property p_rd; c_rd |=> o_core_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_nord; !c_rd |=> !o_core_rvalid; endproperty
    a_nord: assert property (p_nord) else $error("stray read valid");
    property p_fetch; o_fetch_take_sram == (o_core_hit && i_core_req.fetch); endproperty
    a_fetch: assert property (p_fetch) else $error("fetch steer wrong");
    property p_nc; o_core_nocache == o_core_hit; endproperty
    a_nc: assert property (p_nc) else $error("nocache wrong");
    property p_par; both && !same |-> o_core_ready && o_dma_ready; endproperty
    a_par: assert property (p_par) else $error("parallel stalled");
    property p_conf; both && same |-> o_core_ready != o_dma_ready; endproperty
    a_conf: assert property (p_conf) else $error("conflict not arbitrated");
    property p_cpri; both && same |-> o_core_ready && !o_dma_ready; endproperty
    a_cpri: assert property (p_cpri) else $error("core waited on shared array");
    property p_drd; d_rd |=> o_dma_rvalid; endproperty
    a_drd: assert property (p_drd) else $error("dma read not answered");
    property p_dnord; !d_rd |=> !o_dma_rvalid; endproperty
    a_dnord: assert property (p_dnord) else $error("stray dma read valid");
    property p_mask; (base & ~BASE_MASK) == 32'h0; endproperty
    a_mask: assert property (p_mask) else $error("reserved bits set");
endmodule
bind local_bus_sram_block sram_checker u_chk (.i_clk, .i_resetn, .i_core_req, .i_dma_req,
    .o_core_hit, .o_core_ready, .o_fetch_take_sram, .o_core_nocache, .o_core_rvalid,
    .o_dma_hit, .o_dma_ready, .o_dma_rvalid, .o_debug_base_rdata);

// ### testbench/dma_master_model.sv
`timescale 1ns/1ps
module dma_master_model
    import sram_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_go,
    input  wire mem_req_t i_cmd,
    input  wire logic     i_hit,
    input  wire logic     i_ready,
    output mem_req_t      o_req
);
    logic done = 1'b0;
    initial o_req = '0;
    // Ready is judged at the rising edge; the arbiter may flip it before the falling one.
    always @(posedge i_clk) done <= o_req.valid && (!i_hit || i_ready);
    always @(negedge i_clk) begin
        if (i_go) begin
            o_req <= i_cmd;
        end else if (done) begin
            o_req <= '{1'b0, ~o_req.write, 1'b0, o_req.size, ~o_req.addr, ~o_req.wdata};
        end
    end
endmodule

// ### testbench/local_bus_sram_block_tb_top.sv
`timescale 1ns/1ps
module local_bus_sram_block_tb_top;
    import sram_pkg::*;
    typedef struct {logic w; logic f; acc_size_t s; logic [31:0] a, d, e; logic h;} row_t;
    logic         i_clk = 1'b0;
    logic         i_resetn = 1'b0;
    logic         i_core_is_debug = 1'b0;
    logic         go = 1'b0;
    logic         hit, ft, o_core_hit, o_core_ready, o_fetch_take_sram, o_core_nocache;
    logic         o_core_rvalid, o_dma_hit, o_dma_ready, o_dma_rvalid;
    logic [31:0]  o_core_rdata, o_dma_rdata, o_debug_base_rdata;
    mem_req_t     i_core_req = '0, i_dma_req, cmd = '0;
    base_access_t i_ctrl_move = '0, i_debug_base = '0;
    int           err_count = 0, n_compared = 0, cycles = 0;
    row_t rows[8] = '{'{1, 0, SIZE_LONG, 32'h2000_0000, 32'h1122_3344, 0, 1},
        '{1, 0, SIZE_BYTE, 32'h2000_0001, 32'h0000_00aa, 0, 1},
        '{1, 0, SIZE_WORD, 32'h2000_0002, 32'h0000_beef, 0, 1},
        '{0, 0, SIZE_LONG, 32'h2000_0000, 0, 32'h11aa_beef, 1},
        '{1, 0, SIZE_LONG, 32'h2000_fffc, 32'hcafe_f00d, 0, 1},
        '{0, 1, SIZE_LONG, 32'h2000_fffc, 0, 32'hcafe_f00d, 1},
        '{0, 0, SIZE_LONG, 32'h2001_0000, 0, 0, 0},
        '{0, 1, SIZE_LONG, 32'h1fff_fffc, 0, 0, 0}};
    local_bus_sram_block DUT (.i_clk, .i_resetn, .i_core_req, .i_core_is_debug, .i_dma_req,
        .i_ctrl_move, .i_debug_base, .o_core_hit, .o_core_ready, .o_fetch_take_sram,
        .o_core_nocache, .o_core_rdata, .o_core_rvalid, .o_dma_hit, .o_dma_ready,
        .o_dma_rdata, .o_dma_rvalid, .o_debug_base_rdata);
    dma_master_model u_dma (.i_clk, .i_go(go), .i_cmd(cmd), .i_hit(o_dma_hit),
        .i_ready(o_dma_ready), .o_req(i_dma_req));
    always #25 i_clk = ~i_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Releasing drives the inverse so a stale address cannot pass for a held one.
    task automatic acc(input logic w, f, input acc_size_t s, input logic [31:0] a, d);
        @(negedge i_clk);
        i_core_req = '{1'b1, w, f, s, a, d};
        #1 hit = o_core_hit;
        ft = o_fetch_take_sram;
        @(negedge i_clk);
        i_core_req = '{1'b0, ~w, 1'b0, s, ~a, ~d};
    endtask
    task automatic base(input logic dbg, input logic [31:0] v);
        @(negedge i_clk);
        if (dbg) i_debug_base = '{1'b1, v};
        else i_ctrl_move = '{1'b1, v};
        @(negedge i_clk);
        i_debug_base.write = 1'b0;
        i_ctrl_move.write = 1'b0;
    endtask
    task automatic dual(input logic [31:0] ca, da, cd, dd, input logic cr, dr);
        @(negedge i_clk);
        go <= 1'b1;
        cmd <= '{1'b1, 1'b0, 1'b0, SIZE_LONG, da, 32'h0};
        @(negedge i_clk);
        go <= 1'b0;
        i_core_req = '{1'b1, 1'b0, 1'b0, SIZE_LONG, ca, 32'h0};
        #1 chk(o_core_ready, cr);
        chk(o_dma_ready, dr);
        @(negedge i_clk);
        i_core_req.valid = 1'b0;
        chk(o_core_rdata, cd);
        if (!dr) @(negedge i_clk);
        chk(o_dma_rdata, dd);
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(negedge i_clk);
        i_resetn = 1'b1;
        base(1'b1, 32'h2000_0001);
        for (int i = 0; i < 8; i++) begin
            i_core_is_debug = i[0];
            acc(rows[i].w, rows[i].f, rows[i].s, rows[i].a, rows[i].d);
            chk(hit, rows[i].h);
            chk(ft, rows[i].h & rows[i].f);
            if (!rows[i].w) chk(o_core_rdata, rows[i].e);
        end
        base(1'b1, 32'h2000_ffff);
        chk(o_debug_base_rdata, 32'h2000_0001);
        base(1'b0, 32'h4000_0001);
        chk(o_debug_base_rdata, 32'h4000_0001);
        acc(1'b0, 1'b0, SIZE_LONG, 32'h2000_0000, 32'h0);
        chk(hit, 1'b0);
        acc(1'b1, 1'b0, SIZE_LONG, 32'h4000_0000, 32'h0bad_cafe);
        acc(1'b1, 1'b0, SIZE_LONG, 32'h4000_8000, 32'h1234_5678);
        dual(32'h4000_0000, 32'h4000_0000, 32'h0bad_cafe, 32'h0bad_cafe, 1'b1, 1'b0);
        dual(32'h4000_0000, 32'h4000_8000, 32'h0bad_cafe, 32'h1234_5678, 1'b1, 1'b1);
        @(negedge i_clk);
        i_resetn = 1'b0;
        @(negedge i_clk);
        i_resetn = 1'b1;
        chk(o_debug_base_rdata, 32'h4000_0000);
        acc(1'b0, 1'b0, SIZE_LONG, 32'h4000_0000, 32'h0);
        chk(hit, 1'b0);
        finish_test();
    end
endmodule
